// File: occ_pkg.sv
// Purpose: constants and carrier types for the oscillator, pll and reference clock control
// Assumes: 32-bit classic wishbone register access, one system clock
// Notes: field positions follow the register layouts below
// Summary of operation
// - lock bit freezes clock and pll selections
// - wait enters sleep or idle per bit
// - fail monitor event sets clock fail flag
// - secondary oscillator enable follows its bit
// - switch request starts switch, clears when done
// - switch request resets from two-speed fuse
// - osc and pll writes need the unlock sequence first
// - post divider codes give 1 to 256
// - multiplier codes give 2x to 24x
// - pll input select resets from fuse
// - refclk divider zero passes source through
// - refclk runs only while enabled
// - stop in idle halts refclk in idle
// - pin driven only while output enabled
// - run in sleep keeps output in sleep
// - divider switch bit clears when applied
// - request status bit shows active request
// - run in sleep ignored for system clock
// - refclk source codes 0 to 7 select eight sources
// - new source codes, 110/111 act fast rc
package occ_pkg;
  // register byte offsets
  localparam logic [3:0] OCC_OFF_OSC = 4'h0;
  localparam logic [3:0] OCC_OFF_PLL = 4'h4;
  localparam logic [3:0] OCC_OFF_REF = 4'h8;
  localparam logic [3:0] OCC_OFF_UNLOCK = 4'hC;
  // unlock keys, written in order to the unlock register
  localparam logic [31:0] OCC_KEY1 = 32'hAA99_6655;
  localparam logic [31:0] OCC_KEY2 = 32'h5566_99AA;
  // oscillator control fields
  localparam int OCC_OSC_LOCK = 7;
  localparam int OCC_OSC_SLP = 4;
  localparam int OCC_OSC_CF = 3;
  localparam int OCC_OSC_SECONDARY_OSCILLATOR = 1;
  localparam int OCC_OSC_SW = 0;
  localparam int OCC_OSC_NEW = 8;
  localparam int OCC_OSC_CUR = 12;
  // pll control fields
  localparam int OCC_PLL_ICLK = 7;
  localparam int OCC_PLL_MUL = 16;
  localparam int OCC_PLL_DIV = 24;
  localparam logic [6:0] OCC_MUL_RST = 7'h01;
  localparam logic [6:0] OCC_MUL_MAX = 7'h06;
  localparam logic [2:0] OCC_PDIV_RST = 3'h0;
  // reference clock control fields
  localparam int OCC_REF_DIV = 16;
  localparam int OCC_REF_ON = 15;
  localparam int OCC_REF_STOP_IN_IDLE = 13;
  localparam int OCC_REF_OE = 12;
  localparam int OCC_REF_REFCLK_RUN_IN_SLEEP = 11;
  localparam int OCC_REF_DSW = 9;
  localparam int OCC_REF_ACT = 8;
  localparam logic [3:0] OCC_ROSEL_SYS = 4'h0;
  // switch settle time in cycles after target ready
  localparam int OCC_SW_SETTLE = 4;

  typedef enum logic [2:0] {
    OCC_NS_FRCDIV = 3'b000,
    OCC_NS_SYSTEM_PLL = 3'b001,
    OCC_NS_PRIMARY_OSCILLATOR = 3'b010,
    OCC_NS_RSVD = 3'b011,
    OCC_NS_SECONDARY_OSCILLATOR = 3'b100,
    OCC_NS_LOW_POWER_RC_OSCILLATOR = 3'b101
  } occ_nsrc_t;

  // power-on configuration fuses
  typedef struct packed {
    logic two_speed_startup_fuse;
    logic pll_source_fuse;
    logic [2:0] new_source_fuse;
  } occ_fuse_t;

  // pll settings handed to the analog pll
  typedef struct packed {
    logic pll_input_select;
    logic [6:0] pll_multiplier;
    logic [2:0] pll_post_divider;
  } occ_pll_cfg_t;

  // map a new source code onto its effective source
  function automatic logic [2:0] occ_eff_src(input logic [2:0] code);
    occ_eff_src = (code[2:1] == 2'b11) ? 3'b000 : code;
  endfunction
endpackage

// File: occ_refdiv.sv
// Purpose: reference clock divider, toggles output every div source ticks
// Assumes: source arrives as a one-cycle tick pulse in the system clock domain
// Notes: div of zero passes the tick stream straight through
`timescale 1ns/1ps
module occ_refdiv import occ_pkg::*; #(
  parameter int DW = 15
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [DW-1:0] div_i,
  output logic clk_o
);
  logic [DW-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= '0;
      clk_o <= 1'b0;
    end else if (div_i == '0) begin
      clk_o <= tick_i;
    end else if (tick_i) begin
      if (cnt >= div_i - 1'b1) begin
        cnt <= '0;
        clk_o <= ~clk_o;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

// File: occ_switch.sv
// Purpose: sequences a system clock source change
// Assumes: ready inputs are already synchronised
// Notes: the mux changes over once the target is ready and has settled
`timescale 1ns/1ps
module occ_switch import occ_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [2:0] target_i,
  input wire logic [7:0] ready_i,
  input wire logic [2:0] boot_src_i,
  output logic busy_o,
  output logic done_o,
  output logic [2:0] cur_o
);
  typedef enum logic [1:0] {
    OCC_SW_IDLE = 2'b00,
    OCC_SW_WAIT = 2'b01,
    OCC_SW_SETTLE_ST = 2'b10
  } occ_sw_state_t;
  occ_sw_state_t state;
  logic [2:0] tgt;
  logic [3:0] cnt;
  logic boot;

  // wait for ready, then settle before changeover
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= OCC_SW_IDLE;
      tgt <= 3'h0;
      cnt <= 4'h0;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        OCC_SW_IDLE: begin
          if (start_i) begin
            tgt <= occ_eff_src(target_i);
            busy_o <= 1'b1;
            state <= OCC_SW_WAIT;
          end
        end
        OCC_SW_WAIT: begin
          // reserved target never gets ready; the sequencer stays in wait until reset
          if (tgt != 3'h3 && ready_i[tgt]) begin
            cnt <= 4'h0;
            state <= OCC_SW_SETTLE_ST;
          end
        end
        OCC_SW_SETTLE_ST: begin
          if (cnt == 4'(OCC_SW_SETTLE - 1)) begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state <= OCC_SW_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        default: state <= OCC_SW_IDLE;
      endcase
    end
  end

  // current source: taken from fuses after reset, then from completed switches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_o <= 3'h0;
      boot <= 1'b1;
    end else if (boot) begin
      cur_o <= occ_eff_src(boot_src_i);
      boot <= 1'b0;
    end else if (state == OCC_SW_SETTLE_ST && cnt == 4'(OCC_SW_SETTLE - 1)) begin
      cur_o <= tgt;
    end
  end
endmodule

// File: occ_top.sv
// Purpose: oscillator, system pll and reference clock control registers
// Assumes: classic wishbone slave, 250 MHz system clock, fuses stable at reset
// Notes: analog oscillators live outside; ticks and ready levels come in
`timescale 1ns/1ps
module occ_top import occ_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // configuration and status from the rest of the chip
  input wire occ_fuse_t fuse_i,
  input wire logic fail_detect_i,
  input wire logic wait_exec_i,
  input wire logic wake_i,
  input wire logic [7:0] src_ready_i,
  input wire logic [7:0] ref_tick_i,
  // controls toward clock sources
  output logic secondary_osc_enable_o,
  output logic sleep_o,
  output logic idle_o,
  output logic [2:0] system_clock_sel_o,
  output occ_pll_cfg_t pll_cfg_o,
  output logic refclk_o,
  output logic refclk_oe_o
);
  logic [7:0] rdy_s1, rdy_s2;
  logic [7:0] tick_s1, tick_s2;
  logic fail_s1, fail_s2;
  logic selection_lock, sleep_on_wait, clock_fail_flag, switch_request;
  logic [2:0] new_source_select;
  occ_pll_cfg_t pll;
  logic [14:0] refclk_divider;
  logic ref_on, stop_in_idle, ref_oe, refclk_run_in_sleep, divider_switch_request, ref_active;
  logic [3:0] refclk_source_select;
  logic [14:0] div_live;
  logic [1:0] unlock_step;
  logic boot;
  logic sw_busy, sw_done;
  logic [2:0] cur_src;
  logic ref_run, ref_clk;
  logic wr, rd_ok;
  logic osc_wr, pll_wr, ref_wr, sw_set;
  logic [31:0] wmask;
  logic [31:0] osc_rd, pll_rd, ref_rd;

  // external levels pass two flops before use
  // the first stage feeds only the second, so a metastable level never reaches logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_s1 <= 8'h00;
      rdy_s2 <= 8'h00;
      tick_s1 <= 8'h00;
      tick_s2 <= 8'h00;
      fail_s1 <= 1'b0;
      fail_s2 <= 1'b0;
    end else begin
      rdy_s1 <= src_ready_i;
      rdy_s2 <= rdy_s1;
      tick_s1 <= ref_tick_i;
      tick_s2 <= tick_s1;
      fail_s1 <= fail_detect_i;
      fail_s2 <= fail_s1;
    end
  end

  // byte-lane mask and single-cycle write strobe
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{sel_i[i]}};
    end
  end
  assign wr = cyc_i && stb_i && we_i && !ack_o;
  assign rd_ok = (adr_i[1:0] == 2'b00);

  // write decodes; the two protected registers need the armed unlock
  assign osc_wr = wr && adr_i == OCC_OFF_OSC && unlock_step == 2'd2;
  assign pll_wr = wr && adr_i == OCC_OFF_PLL && unlock_step == 2'd2;
  assign ref_wr = wr && adr_i == OCC_OFF_REF;
  // a start accepted in the completing cycle must beat the clear
  assign sw_set = osc_wr && !selection_lock && wmask[OCC_OSC_SW] && dat_i[OCC_OSC_SW];

  // wishbone acknowledge one cycle after the strobe, dropped the cycle after
  // a strobe left high is answered every other cycle, never twice in a row
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // unlock: two keys in order arm one protected write
  // a wrong key drops the sequence back to the start; a partial-lane unlock write leaves it unchanged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_step <= 2'd0;
    end else if (wr && adr_i == OCC_OFF_UNLOCK && sel_i == 4'hF) begin
      if (dat_i == OCC_KEY1) begin
        unlock_step <= 2'd1;
      end else if (dat_i == OCC_KEY2 && unlock_step == 2'd1) begin
        unlock_step <= 2'd2;
      end else begin
        unlock_step <= 2'd0;
      end
    end else if (wr && (adr_i == OCC_OFF_OSC || adr_i == OCC_OFF_PLL)) begin
      unlock_step <= 2'd0; // one protected write per unlock
    end
  end

  // oscillator control; fuse values caught on the first edge after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      selection_lock <= 1'b0;
      sleep_on_wait <= 1'b0;
      secondary_osc_enable_o <= 1'b0;
      switch_request <= 1'b0;
      new_source_select <= 3'h0;
      boot <= 1'b1;
    end else if (boot) begin
      boot <= 1'b0;
      switch_request <= fuse_i.two_speed_startup_fuse;
      new_source_select <= fuse_i.new_source_fuse;
    end else begin
      if (osc_wr) begin
        if (wmask[OCC_OSC_LOCK]) begin
          selection_lock <= dat_i[OCC_OSC_LOCK];
        end
        if (wmask[OCC_OSC_SLP]) begin
          sleep_on_wait <= dat_i[OCC_OSC_SLP];
        end
        if (wmask[OCC_OSC_SECONDARY_OSCILLATOR]) begin
          secondary_osc_enable_o <= dat_i[OCC_OSC_SECONDARY_OSCILLATOR];
        end
        if (!selection_lock && wmask[OCC_OSC_NEW]) begin
          new_source_select <= dat_i[OCC_OSC_NEW +: 3];
        end
        if (sw_set) begin
          switch_request <= 1'b1;
        end
      end
      // completion clears the request; a new write set wins
      if (sw_done && !sw_set) begin
        switch_request <= 1'b0;
      end
    end
  end

  // failure detection sets the sticky flag, never cleared by software
  // a monitor pulse shorter than one cycle may be missed; it must hold its level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_fail_flag <= 1'b0;
    end else if (fail_s2) begin
      clock_fail_flag <= 1'b1;
    end
  end

  // pll control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll.pll_input_select <= 1'b0;
      pll.pll_multiplier <= OCC_MUL_RST;
      pll.pll_post_divider <= OCC_PDIV_RST;
    end else if (boot) begin
      // input select from pll source fuse
      pll.pll_input_select <= fuse_i.pll_source_fuse;
    end else if (pll_wr && !selection_lock) begin
      if (wmask[OCC_PLL_ICLK]) begin
        pll.pll_input_select <= dat_i[OCC_PLL_ICLK];
      end
      if (wmask[OCC_PLL_MUL] && dat_i[OCC_PLL_MUL +: 7] <= OCC_MUL_MAX) begin
        pll.pll_multiplier <= dat_i[OCC_PLL_MUL +: 7];
      end
      if (wmask[OCC_PLL_DIV]) begin
        pll.pll_post_divider <= dat_i[OCC_PLL_DIV +: 3];
      end
    end
  end

  // wait instruction enters sleep or idle; wake leaves both
  // wake wins over a wait in the same cycle so a late wait cannot strand the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_o <= 1'b0;
      idle_o <= 1'b0;
    end else if (wake_i) begin
      sleep_o <= 1'b0;
      idle_o <= 1'b0;
    end else if (wait_exec_i) begin
      sleep_o <= sleep_on_wait;
      idle_o <= !sleep_on_wait;
    end
  end

  // reference clock control writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refclk_divider <= 15'h0000;
      ref_on <= 1'b0;
      stop_in_idle <= 1'b0;
      ref_oe <= 1'b0;
      refclk_run_in_sleep <= 1'b0;
      divider_switch_request <= 1'b0;
      refclk_source_select <= 4'h0;
    end else begin
      if (ref_wr) begin
        if (wmask[OCC_REF_DIV]) begin
          refclk_divider[7:0] <= dat_i[OCC_REF_DIV +: 8];
        end
        if (wmask[OCC_REF_DIV + 8]) begin
          refclk_divider[14:8] <= dat_i[OCC_REF_DIV + 8 +: 7];
        end
        if (wmask[OCC_REF_ON]) begin
          ref_on <= dat_i[OCC_REF_ON];
          stop_in_idle <= dat_i[OCC_REF_STOP_IN_IDLE];
          ref_oe <= dat_i[OCC_REF_OE];
          refclk_run_in_sleep <= dat_i[OCC_REF_REFCLK_RUN_IN_SLEEP];
          if (dat_i[OCC_REF_DSW]) begin
            divider_switch_request <= 1'b1;
          end
        end
        // source select field; reserved codes give no clock
        if (wmask[0]) begin
          refclk_source_select <= dat_i[3:0];
        end
      end else if (divider_switch_request) begin
        // cleared once the new divider is applied
        divider_switch_request <= 1'b0;
      end
    end
  end

  // new divider takes effect on a switch request or while the module is off
  // the module counts as off until the request status follows the enable,
  // so a divider written together with the enable is applied as well
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_live <= 15'h0000;
    end else if (divider_switch_request || !ref_on || !ref_active) begin
      div_live <= refclk_divider;
    end
  end

  // run conditions
  // sleep stops the output unless run in sleep is set and the source is not system clock
  assign ref_run = ref_on
    && !(idle_o && stop_in_idle)
    && !(sleep_o && (refclk_source_select == OCC_ROSEL_SYS || !refclk_run_in_sleep));

  // request status follows the enable one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_active <= 1'b0;
    end else begin
      ref_active <= ref_on;
    end
  end

  // source codes with the top bit set get no ticks at all
  occ_refdiv #(.DW(15)) u_refdiv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(ref_run),
    .tick_i(tick_s2[refclk_source_select[2:0]] && !refclk_source_select[3]),
    .div_i(div_live),
    .clk_o(ref_clk)
  );

  // pin driven only while output enable set
  // gating with the enable too keeps the pin low in the cycle its enable drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refclk_o <= 1'b0;
      refclk_oe_o <= 1'b0;
    end else begin
      refclk_o <= ref_clk && ref_oe && ref_on;
      refclk_oe_o <= ref_oe && ref_on;
    end
  end

  // source change sequencer
  // start is held off during boot and in the cycle in which done is seen
  occ_switch u_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(switch_request && !sw_busy && !boot && !sw_done),
    .target_i(new_source_select),
    .ready_i(rdy_s2),
    .boot_src_i(fuse_i.new_source_fuse),
    .busy_o(sw_busy),
    .done_o(sw_done),
    .cur_o(cur_src)
  );

  // outputs registered from the settled selections
  // reserved multiplier codes never reach here, they are refused at the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_clock_sel_o <= 3'h0;
      pll_cfg_o <= '0;
    end else begin
      system_clock_sel_o <= cur_src;
      pll_cfg_o <= pll;
    end
  end

  // read images; reserved and unimplemented bits read zero
  assign osc_rd = {17'h0, cur_src, 1'b0, new_source_select, selection_lock, 2'b00,
    sleep_on_wait, clock_fail_flag, 1'b0, secondary_osc_enable_o, switch_request};
  assign pll_rd = {5'h0, pll.pll_post_divider, 1'b0, pll.pll_multiplier, 8'h00,
    pll.pll_input_select, 7'h00};
  assign ref_rd = {1'b0, refclk_divider, ref_on, 1'b0, stop_in_idle, ref_oe,
    refclk_run_in_sleep, 1'b0, divider_switch_request, ref_active, 4'h0, refclk_source_select};

  // read data registered; unmapped addresses read zero
  // loading only on the taken edge keeps the data zero in the ack-drop cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o && rd_ok) begin
      unique case (adr_i)
        OCC_OFF_OSC: dat_o <= osc_rd;
        OCC_OFF_PLL: dat_o <= pll_rd;
        OCC_OFF_REF: dat_o <= ref_rd;
        default: dat_o <= 32'h0000_0000;
      endcase
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end
endmodule

// File: occ_top_sva.sv
// Purpose: bus, low-power mode and refclk pin properties of occ_top
// Assumes: sees only the top ports, one clock domain
// Notes: src_ready_i is held steady by the bench around switches
`timescale 1ns/1ps
module occ_top_chk import occ_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic wait_exec_i,
  input wire logic wake_i,
  input wire logic [7:0] src_ready_i,
  input wire logic sleep_o,
  input wire logic idle_o,
  input wire logic [2:0] system_clock_sel_o,
  input wire occ_pll_cfg_t pll_cfg_o,
  input wire logic refclk_o,
  input wire logic refclk_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // register bus answers every request after exactly one cycle
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_read_quiet: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  // wait and wake steer the low-power mode outputs
  chk_wait_mode: assert property (wait_exec_i && !wake_i |=> sleep_o || idle_o)
    else $error("wait did not enter a low-power mode");
  chk_wake_clear: assert property (wake_i |=> !sleep_o && !idle_o)
    else $error("wake did not leave low-power mode");
  chk_mode_excl: assert property (!(sleep_o && idle_o))
    else $error("sleep and idle both set");
  chk_pin_gated: assert property (!refclk_oe_o |-> !refclk_o)
    else $error("refclk toggles with pin disabled");
  chk_mul_legal: assert property (pll_cfg_o.pll_multiplier <= 7'h06)
    else $error("reserved multiplier reached the pll");
  chk_sel_legal: assert property (system_clock_sel_o[2:1] != 2'h3 && system_clock_sel_o != 3'h3)
    else $error("reserved clock source selected");
  // fuse loading right after reset is exempt from the ready test
  chk_sel_ready: assert property ($changed(system_clock_sel_o) && !$past(rst_i, 2)
    && !$past(rst_i, 3) |-> src_ready_i[system_clock_sel_o])
    else $error("switched to a source that is not ready");
  cov_ack: cover property (cyc_i && stb_i && ack_o);
  cov_sleep: cover property ($rose(sleep_o));
  cov_idle: cover property ($rose(idle_o));
  cov_pin: cover property ($rose(refclk_oe_o));
endmodule

bind occ_top occ_top_chk chk_i (.*);

// File: testbench.sv
// Purpose: self-checking bench for occ_top
// Assumes: all source ticks pulse every other cycle
// Notes: refclk rates judged by edge counts over 40 cycles
`timescale 1ns/1ps
module testbench import occ_pkg::*;;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic we_i = 1'h0;
  logic fail_detect_i = 1'h0;
  logic wait_exec_i = 1'h0;
  logic wake_i = 1'h0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack_o, secondary_osc_enable_o, sleep_o, idle_o, refclk_o, refclk_oe_o;
  logic [2:0] system_clock_sel_o;
  logic [7:0] src_ready_i = 8'h00;
  logic [7:0] ref_tick_i = 8'h00;
  occ_fuse_t fuse_i = '{1'h1, 1'h1, 3'h2};
  occ_pll_cfg_t pll_cfg_o;
  int num_errors = 0;
  int n_checks = 0;
  int cyc_n = 0;
  occ_top dut (.*);
  // clock and free-running source ticks
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) ref_tick_i <= ~ref_tick_i;
  // hang guard: the run needs about 1200 cycles
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // four-state safe range compare
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'h1) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic eq(input logic [31:0] got, input logic [31:0] e);
    chk(got, e, e);
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    @(posedge clk_i);
    while (ack_o !== 1'h1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // protected write: both keys, then the write itself
  task automatic unlk(input logic [3:0] a, input logic [31:0] d);
    bus(1'h1, OCC_OFF_UNLOCK, OCC_KEY1);
    bus(1'h1, OCC_OFF_UNLOCK, OCC_KEY2);
    bus(1'h1, a, d);
  endtask
  task automatic go_wait();
    wait_exec_i <= 1'h1;
    @(posedge clk_i);
    wait_exec_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic go_wake();
    wake_i <= 1'h1;
    @(posedge clk_i);
    wake_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // run refclk with cfg, optionally in low power, count output edges
  task automatic ref_run(input logic [31:0] cfg, input logic md, input int lo, input int hi);
    int c;
    logic p;
    bus(1'h1, OCC_OFF_REF, cfg);
    repeat (4) @(posedge clk_i); // status settles before next write
    if (md) go_wait();
    repeat (2) @(posedge clk_i); // divider and pin stages settle
    c = 0;
    p = refclk_o;
    repeat (40) begin
      @(posedge clk_i);
      if (refclk_o !== p) c++;
      p = refclk_o;
    end
    chk(c, lo, hi);
    go_wake();
    bus(1'h1, OCC_OFF_REF, cfg & 32'hFFFF_7FFF); // module switched off, source kept
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_reset();
    bus(1'h0, OCC_OFF_OSC, 32'h0);
    eq(rd & 32'h0000_0FFF, 32'h0000_0201);
    bus(1'h0, OCC_OFF_PLL, 32'h0);
    eq(rd, 32'h0001_0080);
    bus(1'h0, OCC_OFF_REF, 32'h0);
    eq(rd, 32'h0);
    bus(1'h0, 4'h1, 32'h0);
    eq(rd, 32'h0);
    src_ready_i <= 8'hFF;
    repeat (20) @(posedge clk_i);
    bus(1'h0, OCC_OFF_OSC, 32'h0);
    eq(rd & 32'h0000_0701, 32'h0000_0200);
    eq(system_clock_sel_o, 3'h2);
    $display("test reset done");
  endtask
  task automatic t_pll();
    logic [6:0] m;
    bus(1'h1, OCC_OFF_PLL, 32'h0304_0080);
    eq(pll_cfg_o, {1'h1, 7'h01, 3'h0});
    for (int i = 0; i < 8; i++) begin
      m = (i == 7) ? 7'h00 : i[6:0];
      unlk(OCC_OFF_PLL, {5'h0, i[2:0], 1'h0, m, 16'h0080});
      eq(pll_cfg_o, {1'h1, m, i[2:0]});
    end
    unlk(OCC_OFF_PLL, 32'h077F_0080);
    eq(pll_cfg_o, {1'h1, 7'h00, 3'h7});
    bus(1'h1, OCC_OFF_PLL, 32'h0);
    eq(pll_cfg_o, {1'h1, 7'h00, 3'h7});
    $display("test pll done");
  endtask
  task automatic t_switch();
    unlk(OCC_OFF_OSC, 32'h0000_0503);
    repeat (20) @(posedge clk_i);
    eq(system_clock_sel_o, 3'h5);
    eq(secondary_osc_enable_o, 1'h1);
    unlk(OCC_OFF_OSC, 32'h0000_0601);
    repeat (20) @(posedge clk_i);
    eq(system_clock_sel_o, 3'h0);
    eq(secondary_osc_enable_o, 1'h0);
    unlk(OCC_OFF_OSC, 32'h0000_0080);
    unlk(OCC_OFF_OSC, 32'h0000_0281);
    repeat (20) @(posedge clk_i);
    eq(system_clock_sel_o, 3'h0);
    unlk(OCC_OFF_PLL, 32'h0);
    eq(pll_cfg_o, {1'h1, 7'h00, 3'h7});
    $display("test switch done");
  endtask
  task automatic t_modes();
    unlk(OCC_OFF_OSC, 32'h0000_0090);
    go_wait();
    eq({sleep_o, idle_o}, 2'h2);
    go_wake();
    eq({sleep_o, idle_o}, 2'h0);
    unlk(OCC_OFF_OSC, 32'h0000_0080);
    go_wait();
    eq({sleep_o, idle_o}, 2'h1);
    go_wake();
    fail_detect_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    fail_detect_i <= 1'h0;
    bus(1'h0, OCC_OFF_OSC, 32'h0);
    eq(rd & 32'h8, 32'h8);
    $display("test modes done");
  endtask
  task automatic t_ref();
    int srcs[7] = '{0, 2, 3, 4, 5, 7, 8};
    foreach (srcs[k]) ref_run(32'h9000 | srcs[k], 1'h0, srcs[k] == 8 ? 0 : 36,
      srcs[k] == 8 ? 0 : 40);
    ref_run(32'h0002_9003, 1'h0, 8, 11);
    ref_run(32'h0000_8003, 1'h0, 0, 0);
    ref_run(32'h0000_1003, 1'h0, 0, 0);
    ref_run(32'h0000_B003, 1'h1, 0, 0);
    ref_run(32'h0000_9003, 1'h1, 36, 40);
    bus(1'h1, OCC_OFF_REF, 32'h0001_9203);
    eq(refclk_oe_o, 1'h1);
    repeat (4) @(posedge clk_i);
    bus(1'h0, OCC_OFF_REF, 32'h0);
    eq(rd, 32'h0001_9103);
    bus(1'h1, OCC_OFF_REF, 32'h0001_1003);
    repeat (4) @(posedge clk_i);
    bus(1'h0, OCC_OFF_REF, 32'h0);
    eq(rd, 32'h0001_1003);
    unlk(OCC_OFF_OSC, 32'h0000_0090);
    ref_run(32'h0000_9803, 1'h1, 36, 40);
    ref_run(32'h0000_9003, 1'h1, 0, 0);
    ref_run(32'h0000_9800, 1'h1, 0, 0);
    $display("test refclk done");
  endtask
  // second reset with the two-speed and pll fuses cleared
  task automatic t_fuse();
    fuse_i <= '{1'h0, 1'h0, 3'h4};
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    bus(1'h0, OCC_OFF_OSC, 32'h0);
    eq(rd & 32'h0000_7FFF, 32'h0000_4400);
    bus(1'h0, OCC_OFF_PLL, 32'h0);
    eq(rd, 32'h0001_0000);
    $display("test fuse done");
  endtask
  // reset for four cycles, then the scenarios in order
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_pll();
    t_switch();
    t_modes();
    t_ref();
    t_fuse();
    give_verdict();
  end
endmodule
